// ---- rtl/qtp_pkg.sv ----
`default_nettype none
package qtp_pkg;
  // apb address width and register byte offsets
  localparam int          APB_AW        = 8;
  localparam logic [7:0]  OFS_UNIT_MODE = 8'h00;
  localparam logic [7:0]  OFS_CNT_CTRL  = 8'h04;
  localparam logic [7:0]  OFS_PERIOD    = 8'h08;
  localparam logic [7:0]  OFS_DUTY      = 8'h0c;
  localparam logic [7:0]  OFS_COUNT     = 8'h10;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h18;

  // unit_mode_reg fields
  localparam int          UM_UDC        = 0;
  localparam int          UM_OUT_EN     = 1;
  localparam int          UM_ACT_LVL    = 2;
  localparam int          UM_PIN6_MODE  = 3;
  localparam int          UM_EDGE_LO    = 4;
  localparam int          UM_EDGE_HI    = 5;
  localparam int          UM_W          = 6;
  localparam logic [5:0]  UM_RST        = 6'h00;

  // counter_control_reg fields
  localparam int          CC_PRE_LO     = 0;
  localparam int          CC_PRE_HI     = 1;
  localparam int          CC_PRE_EXT    = 2;
  localparam int          CC_EXT_CLK    = 5;
  localparam int          CC_CLR_EN     = 6;
  localparam int          CC_CNT_EN     = 7;
  localparam int          CC_W          = 8;
  localparam logic [7:0]  CC_RST        = 8'h00;

  // interrupt status and mask layout
  localparam int          IRQ_PERIOD    = 0;
  localparam int          IRQ_DUTY      = 1;
  localparam int          IRQ_W         = 2;
  localparam logic [1:0]  IRQ_RST       = 2'h0;

  // compare and counter values after reset
  localparam logic [15:0] PERIOD_RST    = 16'hffff;
  localparam logic [15:0] DUTY_RST      = 16'h0000;
  localparam logic [15:0] COUNT_RST     = 16'h0000;

  // both prescale bits set selects x4 quadrature
  localparam logic [1:0]  QUAD_MODE     = 2'h3;

  // internal count clocks: fclk/4 up to fclk/128
  localparam int          NUM_CLK_SRC   = 6;
  localparam int          PRE_W         = 7;
  localparam logic [7:0]  MIN_DIV       = 8'h04;
endpackage
`default_nettype wire

// ---- rtl/qtp_quad_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module qtp_quad_decode (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // encoder phases
  input  wire logic phaseA,
  input  wire logic phaseB,
  // decoded step
  output logic      edgeA,
  output logic      edgeB,
  output logic      step,
  output logic      up,
  output logic      dirHeld
);
  typedef struct packed {
    logic aPrev;
    logic bPrev;
    logic dirUp;
  } qtp_quad_s;

  qtp_quad_s st_reg;
  qtp_quad_s st_next;

  always_comb begin
    edgeA   = phaseA ^ st_reg.aPrev;
    edgeB   = phaseB ^ st_reg.bPrev;
    dirHeld = st_reg.dirUp;
    step    = edgeA | edgeB;
    if (edgeA && edgeB) begin
      up = st_reg.dirUp;
    end else if (edgeA) begin
      up = phaseA ^ phaseB;
    end else begin
      up = ~(phaseA ^ phaseB);
    end
    st_next       = st_reg;
    st_next.aPrev = phaseA;
    st_next.bPrev = phaseB;
    st_next.dirUp = step ? up : st_reg.dirUp;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{aPrev: 1'b0, bPrev: 1'b0, dirUp: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // qtp_quad_decode
`default_nettype wire

// ---- rtl/qtp_timer.sv ----
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - up/down mode, external clock, both prescale bits set: x4 quadrature count
// - four counts per encoder cycle
// - edge selection ignored in x4 mode
// - simultaneous edges keep previous direction
// - pwm output only in timer mode
// - 16-bit, six internal count clocks
// - output enable gates pin; level selects polarity
// - count enable starts counting and waveform
// - period match raises interrupt, held
// - period clear on next count clock
// - duty match raises interrupt, ends active
// - equal compares keep output inactive
module qtp_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [qtp_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // encoder count clock input
  input  wire logic                       countClockInput,
  // shared pin 6: direction input or pwm output
  input  wire logic                       sharedPin6In,
  output logic                            sharedPin6Out,
  output logic                            sharedPin6Oe_n,
  // interrupts
  output logic                            periodMatchIrq,
  output logic                            dutyMatchIrq,
  output logic                            irq
);
  import qtp_pkg::*;

  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("qtp_timer: CNT_W must be 2 to 16");
  end

  typedef struct packed {
    logic [UM_W-1:0]  unitMode;
    logic [CC_W-1:0]  ctrl;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] duty;
    logic [CNT_W-1:0] count;
    logic [PRE_W-1:0] pre;
    logic             periodHit;
    logic             pwmActive;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic             periodPulse;
    logic             dutyPulse;
    logic             pinOut;
    logic             pinOe_n;
    logic [31:0]      rdata;
    logic             slvErr;
  } qtp_state_s;

  qtp_state_s st_reg;
  qtp_state_s st_next;

  // terminal value of the prescaler for a clock select
  function automatic logic [PRE_W-1:0] divLast(input logic [2:0] sel);
    logic [2:0] idx;
    idx = (sel > 3'(NUM_CLK_SRC - 1)) ? 3'(NUM_CLK_SRC - 1) : sel;
    return PRE_W'((MIN_DIV << idx) - 8'h01);
  endfunction

  // zero-extend a counter-wide value to the bus
  function automatic logic [31:0] busWord(input logic [CNT_W-1:0] v);
    return 32'(v);
  endfunction

  logic             setupPh;
  logic             accessPh;
  logic             wrStrobe;
  logic             udcMode;
  logic             extClk;
  logic             running;
  logic             quadMode;
  logic             preDone;
  logic             tick;
  logic             countUp;
  logic             restart;
  logic             periodEvt;
  logic             dutyEvt;
  logic             pinDrive;
  logic [CNT_W-1:0] cntNext;
  logic             qEdgeA;
  logic             qEdgeB;
  logic             qStep;
  logic             qUp;
  logic             qDirHeld;

  qtp_quad_decode u_quad (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .phaseA  (countClockInput),
    .phaseB  (sharedPin6In),
    .edgeA   (qEdgeA),
    .edgeB   (qEdgeB),
    .step    (qStep),
    .up      (qUp),
    .dirHeld (qDirHeld)
  );

  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable;
  assign wrStrobe = accessPh && pwrite;
  assign udcMode  = st_reg.unitMode[UM_UDC];
  assign extClk   = st_reg.ctrl[CC_EXT_CLK];
  assign running  = st_reg.ctrl[CC_CNT_EN];
  // quadrature when both prescale bits set
  assign quadMode = udcMode && extClk
                    && (st_reg.ctrl[CC_PRE_HI:CC_PRE_LO] == QUAD_MODE);
  assign preDone  = st_reg.pre >= divLast(st_reg.ctrl[CC_PRE_EXT:CC_PRE_LO]);
  assign tick     = running && (quadMode ? qStep : (!extClk && preDone));
  assign countUp  = quadMode ? qUp : 1'b1;
  // clear one count clock after the match
  assign restart  = st_reg.periodHit && st_reg.ctrl[CC_CLR_EN];
  assign cntNext  = restart ? '0
                    : (countUp ? st_reg.count + 1'b1 : st_reg.count - 1'b1);
  assign periodEvt = tick && (cntNext == st_reg.period);
  assign dutyEvt   = tick && (cntNext == st_reg.duty);
  // pin only ours once set to control mode
  assign pinDrive  = st_reg.unitMode[UM_PIN6_MODE] && !udcMode
                     && st_reg.unitMode[UM_OUT_EN];

  assign prdata         = st_reg.rdata;
  assign pready         = accessPh;
  assign pslverr        = accessPh && st_reg.slvErr;
  assign sharedPin6Out  = st_reg.pinOut;
  assign sharedPin6Oe_n = st_reg.pinOe_n;
  assign periodMatchIrq = st_reg.periodPulse;
  assign dutyMatchIrq   = st_reg.dutyPulse;
  assign irq            = |(st_reg.status & st_reg.mask);

  always_comb begin
    st_next = st_reg;

    // prescaler restarts whenever the internal clock is not in use
    if (!running || extClk || preDone) begin
      st_next.pre = '0;
    end else begin
      st_next.pre = PRE_W'(st_reg.pre + 1'b1);
    end

    if (tick) begin
      st_next.count = cntNext;
      // hold match until next count clock
      st_next.periodHit = periodEvt;
      if (dutyEvt) begin
        st_next.pwmActive = 1'b0;
      end else if (restart) begin
        st_next.pwmActive = (st_reg.duty != st_reg.period);
      end
    end else if (!running) begin
      // stopped: level resumes where the count stands
      st_next.pwmActive = (st_reg.count < st_reg.duty)
                          && (st_reg.duty != st_reg.period);
    end

    st_next.periodPulse = periodEvt;
    st_next.dutyPulse   = dutyEvt;

    // pin is an output only in timer mode
    st_next.pinOe_n = !pinDrive;
    st_next.pinOut = (running && st_reg.pwmActive)
                     ? st_reg.unitMode[UM_ACT_LVL] : !st_reg.unitMode[UM_ACT_LVL];

    // read data is captured in the setup phase, so zero wait states
    if (setupPh) begin
      st_next.slvErr = 1'b0;
      case (paddr)
        OFS_UNIT_MODE: st_next.rdata = 32'(st_reg.unitMode);
        OFS_CNT_CTRL:  st_next.rdata = 32'(st_reg.ctrl);
        OFS_PERIOD:    st_next.rdata = busWord(st_reg.period);
        OFS_DUTY:      st_next.rdata = busWord(st_reg.duty);
        OFS_COUNT:     st_next.rdata = busWord(st_reg.count);
        OFS_IRQ_STAT:  st_next.rdata = 32'(st_reg.status);
        OFS_IRQ_MASK:  st_next.rdata = 32'(st_reg.mask);
        default: begin
          st_next.rdata  = 32'h0000_0000;
          st_next.slvErr = 1'b1;
        end
      endcase
    end

    // writes take effect at the access edge
    if (wrStrobe) begin
      case (paddr)
        OFS_UNIT_MODE: st_next.unitMode = pwdata[UM_W-1:0];
        OFS_CNT_CTRL:  st_next.ctrl     = pwdata[CC_W-1:0];
        OFS_PERIOD:    st_next.period   = pwdata[CNT_W-1:0];
        OFS_DUTY:      st_next.duty     = pwdata[CNT_W-1:0];
        OFS_IRQ_MASK:  st_next.mask     = pwdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    // write-one-to-clear; a new event wins over the clear
    st_next.status = st_reg.status;
    if (wrStrobe && paddr == OFS_IRQ_STAT) begin
      st_next.status = st_reg.status & ~pwdata[IRQ_W-1:0];
    end
    if (periodEvt) begin
      st_next.status[IRQ_PERIOD] = 1'b1;
    end
    if (dutyEvt) begin
      st_next.status[IRQ_DUTY] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.unitMode    <= UM_RST;
      st_reg.ctrl        <= CC_RST;
      st_reg.period      <= PERIOD_RST[CNT_W-1:0];
      st_reg.duty        <= DUTY_RST[CNT_W-1:0];
      st_reg.count       <= COUNT_RST[CNT_W-1:0];
      st_reg.pre         <= '0;
      st_reg.periodHit   <= 1'b0;
      st_reg.pwmActive   <= 1'b0;
      st_reg.status      <= IRQ_RST;
      st_reg.mask        <= IRQ_RST;
      st_reg.periodPulse <= 1'b0;
      st_reg.dutyPulse   <= 1'b0;
      st_reg.pinOut      <= 1'b1;
      st_reg.pinOe_n     <= 1'b1;
      st_reg.rdata       <= 32'h0000_0000;
      st_reg.slvErr      <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_quad_up;
    quadMode && running && qStep && qUp && !restart
    |=> st_reg.count == CNT_W'($past(st_reg.count) + 1'b1);
  endproperty
  a_quad_up: assert property (p_quad_up)
    else $error("quadrature up step did not add one");

  property p_quad_every_edge;
    quadMode && running && (qEdgeA ^ qEdgeB) |-> tick;
  endproperty
  a_quad_every_edge: assert property (p_quad_every_edge)
    else $error("single encoder edge gave no count");

  property p_quad_same_dir;
    quadMode && qEdgeA && qEdgeB |-> qStep && (qUp == qDirHeld);
  endproperty
  a_quad_same_dir: assert property (p_quad_same_dir)
    else $error("coincident edges changed direction");

  property p_udc_no_drive;
    udcMode |=> sharedPin6Oe_n;
  endproperty
  a_udc_no_drive: assert property (p_udc_no_drive)
    else $error("pin driven in up/down mode");

  property p_out_disabled;
    !st_reg.unitMode[UM_OUT_EN] ##1 !st_reg.unitMode[UM_OUT_EN] |-> sharedPin6Oe_n;
  endproperty
  a_out_disabled: assert property (p_out_disabled)
    else $error("pin driven with output disabled");

  property p_prescale_gap;
    tick && !quadMode && $stable(st_reg.ctrl) |=> !tick [*3];
  endproperty
  a_prescale_gap: assert property (p_prescale_gap)
    else $error("internal count clock faster than fclk/4");

  property p_stopped_holds;
    !running |=> $stable(st_reg.count);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("counter moved while disabled");

  property p_stopped_inactive;
    !running |=> sharedPin6Out != $past(st_reg.unitMode[UM_ACT_LVL]);
  endproperty
  a_stopped_inactive: assert property (p_stopped_inactive)
    else $error("stopped counter left pin active");

  property p_period_irq;
    periodEvt |=> periodMatchIrq && st_reg.status[IRQ_PERIOD] && st_reg.periodHit;
  endproperty
  a_period_irq: assert property (p_period_irq)
    else $error("period match not flagged");

  property p_clear_late;
    periodEvt |=> st_reg.count == st_reg.period;
  endproperty
  a_clear_late: assert property (p_clear_late)
    else $error("counter cleared on the match itself");

  property p_duty_ends;
    dutyEvt |=> dutyMatchIrq && !st_reg.pwmActive;
  endproperty
  a_duty_ends: assert property (p_duty_ends)
    else $error("duty match did not end active phase");

  property p_equal_inactive;
    tick && restart && (st_reg.duty == st_reg.period) |=> !st_reg.pwmActive;
  endproperty
  a_equal_inactive: assert property (p_equal_inactive)
    else $error("equal compares produced an active phase");

  property p_restart_active;
    tick && restart && st_reg.duty != st_reg.period && st_reg.duty != '0
    |=> st_reg.pwmActive ##1 (sharedPin6Out == $past(st_reg.unitMode[UM_ACT_LVL]));
  endproperty
  a_restart_active: assert property (p_restart_active)
    else $error("cycle restart did not go active");
endmodule // qtp_timer
`default_nettype wire

// ---- verif/qtp_encoder_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// shaft encoder: one step per request, gray for up and down, then a settable quiet gap
module qtp_encoder_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // step request: 0 up, 1 down, 2 both phases at once
  input  wire logic       stepReq,
  input  wire logic [1:0] stepKind,
  input  wire logic [7:0] gapCycles,
  // phases and status
  output logic            phaseA,
  output logic            phaseB,
  output logic            busy
);
  logic [7:0] gapCnt;

  // requests inside the gap are dropped, so the bench must wait
  assign busy = (gapCnt != 8'h00);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phaseA <= 1'b0;
      phaseB <= 1'b0;
      gapCnt <= 8'h00;
    end else if (stepReq && !busy) begin
      gapCnt <= gapCycles;
      if (stepKind == 2'h2) begin
        phaseA <= ~phaseA;
        phaseB <= ~phaseB;
      // gray order, a leading a is up
      end else if ((phaseA == phaseB) == (stepKind == 2'h0)) begin
        phaseA <= ~phaseA;
      end else begin
        phaseB <= ~phaseB;
      end
    end else if (busy) begin
      gapCnt <= gapCnt - 8'h01;
    end
  end
endmodule // qtp_encoder_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qtp_pkg::*;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        encA, encB, pin6, pinOut, oeN, perIrq, dutyIrq, irq, err;
  logic        stepReq, busy;
  logic [1:0]  stepKind;
  logic [7:0]  gap;
  int          n_mismatch, num_checks, cyc, hiCnt, pCnt, dCnt, p;
  logic [7:0]  ofs [7] = '{OFS_UNIT_MODE, OFS_CNT_CTRL, OFS_PERIOD, OFS_DUTY,
                           OFS_COUNT, OFS_IRQ_STAT, OFS_IRQ_MASK};
  logic [31:0] rstv [7] = '{0, 0, 32'h0000ffff, 0, 0, 0, 0};
  logic [7:0]  umv [4] = '{8'h0e, 8'h0f, 8'h0c, 8'h06};
  logic        oev [4] = '{1'b0, 1'b1, 1'b1, 1'b1};

  // shared pin: design drives while oeN is low
  assign pin6 = oeN ? encB : pinOut;

  qtp_timer #(.CNT_W(16)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .countClockInput(encA),
    .sharedPin6In(pin6), .sharedPin6Out(pinOut), .sharedPin6Oe_n(oeN),
    .periodMatchIrq(perIrq), .dutyMatchIrq(dutyIrq), .irq(irq));

  qtp_encoder_model u_enc (
    .clk_sys(clk_sys), .rst_n(rst_n), .stepReq(stepReq),
    .stepKind(stepKind), .gapCycles(gap), .phaseA(encA), .phaseB(encB),
    .busy(busy));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // whole run needs about 10000 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic enc(input logic [1:0] k, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      stepReq  <= 1'b1;
      stepKind <= k;
      @(posedge clk_sys);
      stepReq  <= 1'b0;
      @(posedge clk_sys);
      while (busy) @(posedge clk_sys);
    end
  endtask

  // whole periods make the high count independent of phase
  task automatic measure(input int n);
    hiCnt = 0;
    pCnt = 0;
    dCnt = 0;
    repeat (n) begin
      @(posedge clk_sys);
      hiCnt += int'(pin6 === 1'b1);
      pCnt += int'(perIrq === 1'b1);
      dCnt += int'(dutyIrq === 1'b1);
    end
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rst_n, stepReq, stepKind} = '0;
    gap = 8'h02;
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    repeat (12) @(posedge clk_sys);
    chk(32'(oeN), 32'h1);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rdChk(ofs[i], rstv[i]);
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, OFS_UNIT_MODE, 32'h08);
    apb(1'b1, OFS_UNIT_MODE, 32'h0e);
    apb(1'b1, OFS_PERIOD, 32'h3);
    apb(1'b1, OFS_DUTY, 32'h1);
    apb(1'b1, OFS_IRQ_MASK, 32'h3);
    chk(32'(oeN), 32'h0);
    // selects 6 and 7 must clamp to the slowest clock
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, OFS_CNT_CTRL, 32'hc0 | s);
      p = 16 << ((s > 5) ? 5 : s);
      repeat (2 * p) @(posedge clk_sys);
      measure(2 * p);
      chk(32'(hiCnt), 32'(p / 2));
      chk(32'(pCnt), 32'h2);
      chk(32'(dCnt), 32'h2);
    end
    apb(1'b1, OFS_CNT_CTRL, 32'hc0);
    apb(1'b1, OFS_UNIT_MODE, 32'h0a);
    repeat (32) @(posedge clk_sys);
    measure(32);
    chk(32'(hiCnt), 32'h18);
    apb(1'b1, OFS_UNIT_MODE, 32'h0e);
    apb(1'b1, OFS_DUTY, 32'h3);
    repeat (32) @(posedge clk_sys);
    measure(32);
    chk(32'(hiCnt), 32'h0);
    apb(1'b1, OFS_CNT_CTRL, 32'h40);
    rdChk(OFS_IRQ_STAT, 32'h3);
    chk(32'(irq), 32'h1);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    rdChk(OFS_IRQ_STAT, 32'h2);
    chk(32'(irq), 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h2);
    rdChk(OFS_IRQ_STAT, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_UNIT_MODE, 32'(umv[i]));
      repeat (2) @(posedge clk_sys);
      chk(32'(oeN), 32'(oev[i]));
    end
    // second reset clears the counter left by the pwm runs
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b1, OFS_UNIT_MODE, 32'h31);
    apb(1'b1, OFS_CNT_CTRL, 32'ha3);
    enc(2'h0, 8);
    rdChk(OFS_COUNT, 32'h8);
    gap <= 8'h14;
    enc(2'h1, 3);
    rdChk(OFS_COUNT, 32'h5);
    enc(2'h2, 1);
    rdChk(OFS_COUNT, 32'h4);
    enc(2'h0, 1);
    apb(1'b1, OFS_COUNT, 32'h0);
    rdChk(OFS_COUNT, 32'h5);
    apb(1'b1, OFS_CNT_CTRL, 32'ha2);
    enc(2'h0, 4);
    rdChk(OFS_COUNT, 32'h5);
    chk(32'(oeN), 32'h1);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
